// >>> rtl/irq_regs_pkg.sv
`default_nettype none
package irq_regs_pkg;
    // ---------------------------------------------------
    // Register byte addresses
    // ---------------------------------------------------
    localparam logic [11:0] flag_status_reg_one_addr      = 12'h000; // Flag register
    localparam logic [11:0] enable_control_reg_three_addr = 12'h004; // Enable register
    localparam logic [11:0] priority_control_reg_one_addr = 12'h008; // Priority, first group
    localparam logic [11:0] capture_priority_addr         = 12'h00c; // Priority, capture group
    localparam logic [11:0] irq_status_addr               = 12'h010; // Sticky event status
    localparam logic [11:0] irq_mask_addr                 = 12'h014; // Event mask
    localparam logic [11:0] pending_level_addr            = 12'h018; // Gated request view

    // ---------------------------------------------------
    // Implemented bit masks and reset values
    // ---------------------------------------------------
    localparam logic [15:0] flag_impl_mask  = 16'hfedf; // Bits 8 and 5 absent
    localparam logic [15:0] enable_impl_mask = 16'h4066; // Bits 14,6,5,2,1
    localparam logic [15:0] prio3_impl_mask = 16'h7770; // Three fields
    localparam logic [15:0] prio3_reset     = 16'h4440; // Each field 100
    localparam logic [15:0] zero_word       = 16'h0000; // Cleared word
    localparam logic [2:0]  prio_off        = 3'h0;     // Source disabled code
    localparam int          prio_lo_bit0    = 4;        // Field at 6-4
    localparam int          prio_lo_bit1    = 8;        // Field at 10-8
    localparam int          prio_lo_bit2    = 12;       // Field at 14-12

    // AHB transfer type
    localparam logic [1:0]  htrans_nonseq   = 2'h2;

    // Captured address phase
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
    } ahb_phase_t;
endpackage : irq_regs_pkg
`default_nettype wire

// >>> rtl/irq_flag_enable_priority.sv
`timescale 1ns/1ps
`default_nettype none
module irq_flag_enable_priority
    import irq_regs_pkg::*;
(
    input  wire logic        mclk,        // 50 MHz system clock
    input  wire logic        reset,       // Synchronous, active high
    input  wire logic        hsel,        // AHB slave select
    input  wire logic [31:0] haddr,       // AHB address
    input  wire logic [1:0]  htrans,      // AHB transfer type
    input  wire logic        hwrite,      // AHB write
    input  wire logic [2:0]  hsize,       // AHB size
    input  wire logic [31:0] hwdata,      // AHB write data
    input  wire logic        hready,      // AHB bus ready
    output logic      [31:0] hrdata,      // AHB read data
    output logic             hreadyout,   // Always ready
    output logic             hresp,       // Always OKAY
    input  wire logic [15:0] src_req,     // Peripheral request pulses, flag bit order
    output logic      [15:0] core_req,    // Gated requests to CPU core
    output logic             irq          // Summary interrupt level
);
    // ---------------------------------------------------
    // State
    // ---------------------------------------------------
    logic [15:0] flag_r, flag_nxt;        // Request flags
    logic [15:0] en_r, en_nxt;            // Enable bits
    logic [15:0] pri1_r, pri1_nxt;        // Priority group one
    logic [15:0] pri2_r, pri2_nxt;        // Priority group two
    logic [15:0] sts_r, sts_nxt;          // Sticky event status
    logic [15:0] msk_r, msk_nxt;          // Event mask
    logic [15:0] creq_nxt;                // Next core request
    ahb_phase_t  ph_r, ph_nxt;            // Pending data phase
    logic [31:0] rd_nxt;                  // Next read data
    logic        irq_nxt;                 // Next interrupt level
    logic [15:0] wd;                      // Write data low half
    logic        wr_flag, wr_en, wr_p1, wr_p2, wr_sts, wr_msk;
    logic [15:0] req_ok;                  // Per-source priority nonzero

    assign wd = hwdata[15:0];

    // ---------------------------------------------------
    // Priority gating, one check per field position
    // ---------------------------------------------------
    // Source-to-priority map is fixed here: field k of group one gates
    // flag bit k, field k of group two gates flag bit k+3; others pass.
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_pri
            if (g < 3) begin : g_a
                assign req_ok[g] = pri1_r[4*g+6 -: 3] != prio_off;
            end else if (g < 6) begin : g_b
                assign req_ok[g] = pri2_r[4*(g-3)+6 -: 3] != prio_off;
            end else begin : g_c
                assign req_ok[g] = 1'b1;
            end
        end
    endgenerate

    // ---------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------
    // Address phase capture, write decode, flag set-over-clear
    always_comb begin
        ph_nxt.valid = hsel && hready && htrans == htrans_nonseq;
        ph_nxt.write = hwrite;
        ph_nxt.addr  = haddr[11:0];
        wr_flag = ph_r.valid && ph_r.write && ph_r.addr == flag_status_reg_one_addr;
        wr_en   = ph_r.valid && ph_r.write && ph_r.addr == enable_control_reg_three_addr;
        wr_p1   = ph_r.valid && ph_r.write && ph_r.addr == priority_control_reg_one_addr;
        wr_p2   = ph_r.valid && ph_r.write && ph_r.addr == capture_priority_addr;
        wr_sts  = ph_r.valid && ph_r.write && ph_r.addr == irq_status_addr;
        wr_msk  = ph_r.valid && ph_r.write && ph_r.addr == irq_mask_addr;
        flag_nxt = flag_r;
        if (wr_flag) begin
            flag_nxt = wd & flag_impl_mask;
        end
        flag_nxt = flag_nxt | (src_req & flag_impl_mask);
        en_nxt   = wr_en ? (wd & enable_impl_mask) : en_r;
        pri1_nxt = wr_p1 ? (wd & prio3_impl_mask) : pri1_r;
        pri2_nxt = wr_p2 ? (wd & prio3_impl_mask) : pri2_r;
        sts_nxt  = (wr_sts ? (sts_r & ~wd) : sts_r) | (src_req & flag_impl_mask);
        msk_nxt  = wr_msk ? wd : msk_r;
        creq_nxt = flag_r & en_r & req_ok;
        irq_nxt  = |(sts_r & msk_r);
        rd_nxt   = 32'h0000_0000;
        if (ph_nxt.valid && !hwrite) begin
            case (haddr[11:0])
                flag_status_reg_one_addr:      rd_nxt[15:0] = flag_nxt;
                enable_control_reg_three_addr: rd_nxt[15:0] = en_nxt;
                priority_control_reg_one_addr: rd_nxt[15:0] = pri1_nxt;
                capture_priority_addr:         rd_nxt[15:0] = pri2_nxt;
                irq_status_addr:               rd_nxt[15:0] = sts_nxt;
                irq_mask_addr:                 rd_nxt[15:0] = msk_nxt;
                pending_level_addr:            rd_nxt[15:0] = creq_nxt;
                default:                       rd_nxt = 32'h0000_0000;
            endcase
        end
    end

    // ---------------------------------------------------
    // Registers
    // ---------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            flag_r    <= zero_word;
            en_r      <= zero_word;
            pri1_r    <= prio3_reset;
            pri2_r    <= prio3_reset;
            sts_r     <= zero_word;
            msk_r     <= zero_word;
            ph_r      <= '0;
            hrdata    <= 32'h0000_0000;
            core_req  <= zero_word;
            irq       <= 1'b0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            flag_r    <= flag_nxt;
            en_r      <= en_nxt;
            pri1_r    <= pri1_nxt;
            pri2_r    <= pri2_nxt;
            sts_r     <= sts_nxt;
            msk_r     <= msk_nxt;
            ph_r      <= ph_nxt;
            hrdata    <= rd_nxt;
            core_req  <= creq_nxt;
            irq       <= irq_nxt;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ---------------------------------------------------
    // Checks
    // ---------------------------------------------------
    a_flag_sets_sticky: assert property (@(posedge mclk) disable iff (reset)
        src_req[0] |=> flag_r[0]) else $error("flag not set");
    a_enable_blocks_req: assert property (@(posedge mclk) disable iff (reset)
        !en_r[1] |=> !core_req[1]) else $error("disabled source passed");
    a_prio_zero_blocks: assert property (@(posedge mclk) disable iff (reset)
        pri1_r[6:4] == prio_off |=> !core_req[0]) else $error("priority zero passed");
    a_unimpl_flag_zero: assert property (@(posedge mclk) disable iff (reset)
        (flag_r & ~flag_impl_mask) == zero_word) else $error("unimplemented flag set");
    a_prio_reset_val: assert property (@(posedge mclk)
        $past(reset) && !reset |-> pri2_r == prio3_reset) else $error("priority reset wrong");
    a_enable_passes_req: assert property (@(posedge mclk) disable iff (reset)
        flag_r[1] && en_r[1] && pri1_r[10:8] != prio_off |=> core_req[1]) else $error("enabled flag lost");

    // ---------------------------------------------------
    // Named steps for the bus and field checks
    // ---------------------------------------------------
    // Read request accepted in an address phase
    sequence s_read_req;
        hsel && hready && htrans == htrans_nonseq && !hwrite;
    endsequence

    // Read request to an address past the last register
    sequence s_read_unmapped;
        s_read_req ##0 haddr[11:0] > pending_level_addr;
    endsequence

    // Flag write with every request line quiet
    sequence s_flag_write_quiet;
        wr_flag ##0 src_req == zero_word;
    endsequence

    // Enable register write in its data phase
    sequence s_enable_write;
        wr_en;
    endsequence

    // Priority group one write in its data phase
    sequence s_prio_write;
        wr_p1;
    endsequence

    // ---------------------------------------------------
    // Bus and field checks
    // ---------------------------------------------------
    // Upper half of read data never carries register bits
    a_read_upper_zero: assert property (@(posedge mclk) disable iff (reset)
        s_read_req |=> hrdata[31:16] == zero_word) else $error("upper read half set");

    // Unmapped addresses read back as zero
    a_read_unmapped_zero: assert property (@(posedge mclk) disable iff (reset)
        s_read_unmapped |=> hrdata[15:0] == zero_word) else $error("unmapped read not zero");

    // Software write of the flags lands, masked
    a_flag_write_lands: assert property (@(posedge mclk) disable iff (reset)
        s_flag_write_quiet |=> flag_r == $past(wd & flag_impl_mask)) else $error("flag write lost");

    // Flags never drop without a software write
    a_flag_holds: assert property (@(posedge mclk) disable iff (reset)
        !wr_flag |=> ($past(flag_r) & ~flag_r) == zero_word) else $error("flag dropped by itself");

    // Enable write lands, absent bits stay zero
    a_enable_write_lands: assert property (@(posedge mclk) disable iff (reset)
        s_enable_write |=> en_r == $past(wd & enable_impl_mask)) else $error("enable write lost");

    // Absent enable bits never set
    a_unimpl_enable_zero: assert property (@(posedge mclk) disable iff (reset)
        (en_r & ~enable_impl_mask) == zero_word) else $error("unimplemented enable set");

    // Priority write lands in the three fields only
    a_prio_write_lands: assert property (@(posedge mclk) disable iff (reset)
        s_prio_write |=> pri1_r == $past(wd & prio3_impl_mask)) else $error("priority write lost");

    // Absent priority bits never set in either group
    a_unimpl_prio_zero: assert property (@(posedge mclk) disable iff (reset)
        ((pri1_r | pri2_r) & ~prio3_impl_mask) == zero_word) else $error("unimplemented priority set");

    // A disabled source never reaches the core
    a_core_req_enabled: assert property (@(posedge mclk) disable iff (reset)
        1'b1 |=> (core_req & ~$past(en_r)) == zero_word) else $error("request without enable");

    // Priority zero in group two blocks its source
    a_prio_two_blocks: assert property (@(posedge mclk) disable iff (reset)
        pri2_r[6:4] == prio_off |=> !core_req[3]) else $error("group two priority zero passed");

    // Bus answer is always ready and OKAY
    a_bus_always_ok: assert property (@(posedge mclk) disable iff (reset)
        hreadyout && !hresp) else $error("bus answer not ready or not okay");
endmodule : irq_flag_enable_priority
`default_nettype wire

// >>> verification/irq_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Peripheral request source model
// ------------------------------
module irq_src_model (
    input  wire logic        mclk,   // System clock
    input  wire logic        go,     // Fire strobe from bench
    input  wire logic [15:0] pat,    // Sources that fire
    output logic      [15:0] src_req // One-cycle pulses
);
    // Every pat bit passes, absent flag bits 8 and 5 too; lines idle low between events
    always_ff @(posedge mclk) begin
        src_req <= go ? pat : 16'h0000;
    end
endmodule : irq_src_model
`default_nettype wire

// >>> verification/interrupt_flag_enable_priority_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module interrupt_flag_enable_priority_tb_top import irq_regs_pkg::*;;
    // ------------------------------
    // Stimulus and bookkeeping
    // ------------------------------
    logic mclk = 0, reset = 1, hsel = 0, hwrite = 0, go = 0, hreadyout, hresp, irq;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd, seed = 32'h6d90, e, p1, p2, pat = 0;
    logic [31:0] hrdata;
    logic [15:0] src_req, core_req;
    int          err_total = 0, n_compared = 0, cyc = 0;
    always #10 mclk = ~mclk;
    irq_flag_enable_priority i_dut (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .src_req(src_req), .core_req(core_req), .irq(irq));
    irq_src_model i_src (.mclk(mclk), .go(go), .pat(pat[15:0]), .src_req(src_req));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    // Expected gated requests: enable and nonzero priority
    function automatic logic [15:0] gate(input logic [15:0] fl, en, pa, pb);
        gate = fl & en;
        for (int n = 0; n < 3; n++) begin
            if (pa[4*n+4 +: 3] == 3'h0) gate[n] = 1'b0;
            if (pb[4*n+4 +: 3] == 3'h0) gate[n+3] = 1'b0;
        end
    endfunction : gate
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Single AHB transfer, waits on hready in both phases
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        {hsel, htrans, haddr, hwrite, hsize} <= {1'b1, htrans_nonseq, 20'h0, a, w, 3'h2};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic rw(input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp);
        bus(1'b1, a, d);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({hreadyout, hresp}, 32'h2);
    endtask : rw
    task automatic fire(input logic [31:0] v);
        @(posedge mclk);
        {go, pat} <= {1'b1, v};
        @(posedge mclk) go <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask : fire
    always @(posedge mclk) if (++cyc == 4000) begin err_total++; stop_test(); end
    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        bus(1'b0, priority_control_reg_one_addr, 32'h0); chk(rd, 32'h4440);
        bus(1'b0, capture_priority_addr, 32'h0); chk(rd, 32'h4440);
        bus(1'b0, flag_status_reg_one_addr, 32'h0); chk(rd, 32'h0);
        rw(12'h01c, 32'hffffffff, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed); e = seed & 32'hffff;
            seed = lfsr(seed); p1 = seed & 32'hffff; p2 = seed >> 16;
            seed = lfsr(seed); pat = seed & 32'hffff;
            rw(enable_control_reg_three_addr, e, e & enable_impl_mask);
            rw(priority_control_reg_one_addr, p1, p1 & prio3_impl_mask);
            rw(capture_priority_addr, p2, p2 & prio3_impl_mask);
            rw(flag_status_reg_one_addr, 32'h0, 32'h0);
            fire(seed);
            bus(1'b0, flag_status_reg_one_addr, 32'h0); chk(rd, seed & flag_impl_mask);
            chk(core_req, gate(seed[15:0] & flag_impl_mask, e[15:0] & enable_impl_mask, p1[15:0] & prio3_impl_mask,
                p2[15:0] & prio3_impl_mask));
            bus(1'b0, pending_level_addr, 32'h0);
            chk(rd, gate(seed[15:0] & flag_impl_mask, e[15:0] & enable_impl_mask, p1[15:0] & prio3_impl_mask,
                p2[15:0] & prio3_impl_mask));
        end
        $display("random test done");
        rw(enable_control_reg_three_addr, 32'hffff, 32'h4066);
        fire(32'hffff);
        for (int c = 0; c < 8; c++) begin
            rw(priority_control_reg_one_addr, {c[2:0], 1'b0, c[2:0], 1'b0, c[2:0], 4'h0}, {c[2:0], 1'b0, c[2:0],
                1'b0, c[2:0], 4'h0});
            chk(core_req & 16'h0006, (c == 0) ? 32'h0 : 32'h6);
        end
        rw(enable_control_reg_three_addr, 32'h0, 32'h0);
        bus(1'b0, flag_status_reg_one_addr, 32'h0); chk(rd, 32'hfedf);
        chk(core_req, 32'h0);
        $display("priority test done");
        rw(irq_mask_addr, 32'h0, 32'h0);
        fire(32'hffff);
        chk(irq, 32'h0);
        rw(irq_mask_addr, 32'hffff, 32'hffff);
        chk(irq, 32'h1);
        rw(irq_status_addr, 32'hffff, 32'h0);
        chk(irq, 32'h0);
        $display("interrupt test done");
        stop_test();
    end
endmodule : interrupt_flag_enable_priority_tb_top
`default_nettype wire
